// file: rtl/opp_defines.svh
// Timing and encoding constants for the OTP programming-port controller
`ifndef OPP_DEFINES_SVH
`define OPP_DEFINES_SVH
// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define OPP_CLK_PERIOD_NS 10
`define OPP_T_STEP_NS 100
`define OPP_T_WRITE_STROBE_A_US 100
`define OPP_STEP_CYC ((`OPP_T_STEP_NS + `OPP_CLK_PERIOD_NS - 1) / `OPP_CLK_PERIOD_NS)
`define OPP_WRITE_STROBE_A_CYC ((`OPP_T_WRITE_STROBE_A_US * 1000) / `OPP_CLK_PERIOD_NS)
// ----------------------------------------------------------------
// Access-mode select codes
// ----------------------------------------------------------------
`define OPP_MODE_RSVD 2'h0
`define OPP_MODE_VERSION 2'h1
`define OPP_MODE_LOCK 2'h2
`define OPP_MODE_MEMORY 2'h3
`define OPP_ADDR_W 16
`define OPP_DATA_W 8
`endif

// file: rtl/opp_pkg.sv
// Types for the OTP programming-port controller
`include "opp_defines.svh"
package opp_pkg;
  // Host command
  typedef struct packed {
    logic write;
    logic [1:0] mode;
    logic [`OPP_ADDR_W-1:0] addr;
    logic [`OPP_DATA_W-1:0] data;
  } opp_cmd_t;
  // Pins driven toward the device
  typedef struct packed {
    logic dev_reset_n;
    logic code_fetch_enable_n;
    logic basic_mode_select;
    logic access_sel_hi;
    logic access_sel_lo;
    logic addr_latch_strobe;
    logic write_strobe_a_read_strobe_n;
    logic write_strobe_a_n;
    logic vpp_high;
    logic ea_level;
    logic data_oe;
    logic [`OPP_DATA_W-1:0] data_o;
    logic [`OPP_DATA_W-1:0] addr_o;
  } opp_pins_t;
  typedef enum logic [3:0] {
    ST_ENTER_LOW, ST_ENTER_SEL, ST_IDLE, ST_SEL, ST_ALE_HI, ST_ALE_LO, ST_LO_ADDR,
    ST_RD_STB, ST_WR_SET, ST_WR_PULSE, ST_WR_DONE, ST_RSP
  } opp_state_t;
endpackage

// file: rtl/opp_programmer.sv
// Host controller driving the OTP programming-mode pins of the device
// Functional notes
// - Hold program-store-enable low throughout
// - Mode 00 reserved, 01 version, 10 lock, 11 memory
// - High address byte latched on strobe fall
// - Port carries high byte, then low byte
// - Read strobe for reads; device drives then
// - Write strobe triggers byte and lock programming
// - Write strobe low during mode entry
// - Voltage pin low during mode entry
// - Data port bidirectional, eight bits
// - Basic-mode select switched to enter mode
`timescale 1ns/100ps
`default_nettype none
`include "opp_defines.svh"
module opp_programmer
  import opp_pkg::*;
#(
  parameter int unsigned WRITE_STROBE_A_CYC = `OPP_WRITE_STROBE_A_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire opp_cmd_t cmd,
  output logic rsp_valid,
  output logic rsp_error,
  output logic [`OPP_DATA_W-1:0] rsp_data,
  output logic mode_ready,
  output logic dev_reset_n,
  output logic code_fetch_enable_n,
  output logic basic_mode_select,
  output logic access_sel_hi,
  output logic access_sel_lo,
  output logic addr_latch_strobe,
  output logic write_strobe_a_read_strobe_n,
  output logic write_strobe_a_n,
  output logic ext_access_write_strobe_a_voltage_hi,
  output logic ext_access_write_strobe_a_voltage_lvl,
  output logic [`OPP_DATA_W-1:0] muxed_address_port,
  output logic [`OPP_DATA_W-1:0] write_strobe_a_data_port_o,
  output logic write_strobe_a_data_port_oe,
  input wire logic [`OPP_DATA_W-1:0] write_strobe_a_data_port_i
);
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  localparam logic [15:0] STEP = 16'(`OPP_STEP_CYC);
  localparam logic [15:0] PULSE = 16'(WRITE_STROBE_A_CYC);
  opp_state_t state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  opp_cmd_t cmd_r;
  opp_pins_t pins_r, pins_nxt;
  logic err_r;
  logic take;
  logic step_done;
  opp_cmd_t cur_cmd;
  localparam int LO_DLY = `OPP_STEP_CYC + 1;

  assign step_done = (cnt_r == 16'h0000);
  assign cmd_ready = (state_r == ST_IDLE);
  assign take = cmd_ready && cmd_valid;
  // Pins launched at the take edge must see the new command, not the old one
  assign cur_cmd = take ? cmd : cmd_r;

  // Next state; each step holds its pins for STEP+1 cycles, the write pulse for PULSE cycles, a reserved-mode response for one cycle
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = step_done ? cnt_r : cnt_r - 16'h0001;
    if (state_r == ST_IDLE) begin
      if (take) begin
        state_nxt = (cmd.mode == `OPP_MODE_RSVD) ? ST_RSP : ST_SEL;
        // Select gets a full step of setup ahead of the latch strobe
        cnt_nxt = (cmd.mode == `OPP_MODE_RSVD) ? 16'h0000 : STEP;
      end
    end else if (step_done) begin
      cnt_nxt = STEP;
      unique case (state_r)
        ST_ENTER_LOW: state_nxt = ST_ENTER_SEL;
        ST_ENTER_SEL: state_nxt = ST_IDLE;
        ST_SEL: state_nxt = ST_ALE_HI;
        ST_ALE_HI: state_nxt = ST_ALE_LO;
        ST_ALE_LO: state_nxt = ST_LO_ADDR;
        ST_LO_ADDR: state_nxt = cmd_r.write ? ST_WR_SET : ST_RD_STB;
        ST_RD_STB: state_nxt = ST_RSP;
        ST_WR_SET: begin
          state_nxt = ST_WR_PULSE;
          cnt_nxt = PULSE - 16'h0001;
        end
        ST_WR_PULSE: state_nxt = ST_WR_DONE;
        ST_WR_DONE: state_nxt = ST_RSP;
        ST_RSP: begin
          state_nxt = ST_IDLE;
          cnt_nxt = 16'h0000;
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  // State and step counter
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_ENTER_LOW;
      cnt_r <= STEP;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Command capture; held for the whole access
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_r <= '0;
      err_r <= 1'b0;
    end else if (take) begin
      cmd_r <= cmd;
      err_r <= (cmd.mode == `OPP_MODE_RSVD);
    end
  end

  // ----------------------------------------------------------------
  // Pin decode, registered so the device sees clean levels
  // ----------------------------------------------------------------
  always_comb begin
    pins_nxt = pins_r;
    // reset and store enable stay low
    pins_nxt.dev_reset_n = 1'b0;
    pins_nxt.code_fetch_enable_n = 1'b0;
    pins_nxt.basic_mode_select = (state_nxt == ST_ENTER_SEL);
    // high byte stands across strobe fall
    pins_nxt.addr_latch_strobe = (state_nxt == ST_ALE_HI);
    // read strobe only in the read step
    pins_nxt.write_strobe_a_read_strobe_n = (state_nxt != ST_RD_STB);
    // write strobe low in entry, low for programming
    pins_nxt.write_strobe_a_n = !(state_nxt == ST_ENTER_LOW || state_nxt == ST_ENTER_SEL ||
                                  state_nxt == ST_WR_PULSE);
    // programming voltage spans data setup to release
    pins_nxt.vpp_high = (state_nxt == ST_WR_SET || state_nxt == ST_WR_PULSE || state_nxt == ST_WR_DONE);
    // low in entry, logic high otherwise
    pins_nxt.ea_level = !(state_nxt == ST_ENTER_LOW || state_nxt == ST_ENTER_SEL);
    // we drive data only for writes
    pins_nxt.data_oe = pins_nxt.vpp_high;
    pins_nxt.data_o = cur_cmd.data;
    unique case (state_nxt)
      // mode select moves while latch strobe is low
      ST_SEL: begin
        pins_nxt.access_sel_hi = cur_cmd.mode[1];
        pins_nxt.access_sel_lo = cur_cmd.mode[0];
        pins_nxt.addr_o = cur_cmd.addr[15:8];
      end
      ST_LO_ADDR: pins_nxt.addr_o = cur_cmd.addr[7:0];
      default: pins_nxt.addr_o = pins_r.addr_o;
    endcase
  end

  // Pin register; reset values already match the entry step
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pins_r <= '{dev_reset_n: 1'b0, code_fetch_enable_n: 1'b0, basic_mode_select: 1'b0,
                  access_sel_hi: 1'b0, access_sel_lo: 1'b0, addr_latch_strobe: 1'b0,
                  write_strobe_a_read_strobe_n: 1'b1, write_strobe_a_n: 1'b0, vpp_high: 1'b0,
                  ea_level: 1'b0, data_oe: 1'b0, data_o: 8'h00, addr_o: 8'h00};
    end else begin
      pins_r <= pins_nxt;
    end
  end

  // Read data sampled at the end of the strobe, while still low
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_data <= 8'h00;
    end else if (state_r == ST_RD_STB && step_done) begin
      rsp_data <= write_strobe_a_data_port_i;
    end
  end

  // Response strobe
  assign rsp_valid = (state_r == ST_RSP) && step_done;
  assign rsp_error = err_r;
  assign mode_ready = (state_r != ST_ENTER_LOW) && (state_r != ST_ENTER_SEL);
  assign dev_reset_n = pins_r.dev_reset_n;
  assign code_fetch_enable_n = pins_r.code_fetch_enable_n;
  assign basic_mode_select = pins_r.basic_mode_select;
  assign access_sel_hi = pins_r.access_sel_hi;
  assign access_sel_lo = pins_r.access_sel_lo;
  assign addr_latch_strobe = pins_r.addr_latch_strobe;
  assign write_strobe_a_read_strobe_n = pins_r.write_strobe_a_read_strobe_n;
  assign write_strobe_a_n = pins_r.write_strobe_a_n;
  assign ext_access_write_strobe_a_voltage_hi = pins_r.vpp_high;
  assign ext_access_write_strobe_a_voltage_lvl = pins_r.ea_level;
  assign muxed_address_port = pins_r.addr_o;
  assign write_strobe_a_data_port_o = pins_r.data_o;
  assign write_strobe_a_data_port_oe = pins_r.data_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_sel_ale_low: assert property (@(posedge core_clk) disable iff (!reset_n)
    ($changed(access_sel_hi) || $changed(access_sel_lo)) |-> !addr_latch_strobe)
    else $error("mode select changed with latch strobe high");
  a_hi_addr_fall: assert property (@(posedge core_clk) disable iff (!reset_n)
    $fell(addr_latch_strobe) |-> muxed_address_port == cmd_r.addr[15:8])
    else $error("high address byte not held at latch fall");
  a_lo_addr_next: assert property (@(posedge core_clk) disable iff (!reset_n)
    $fell(addr_latch_strobe) |-> ##LO_DLY muxed_address_port == cmd_r.addr[7:0])
    else $error("low address byte not presented after latch");
  a_reset_held: assert property (@(posedge core_clk) disable iff (!reset_n)
    !dev_reset_n && !code_fetch_enable_n)
    else $error("reset or store enable released");
  a_vpp_write_strobe_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!write_strobe_a_n && mode_ready) |-> ext_access_write_strobe_a_voltage_hi && write_strobe_a_data_port_oe)
    else $error("write strobe without programming voltage");
  a_read_level: assert property (@(posedge core_clk) disable iff (!reset_n)
    !write_strobe_a_read_strobe_n |-> ext_access_write_strobe_a_voltage_lvl && !ext_access_write_strobe_a_voltage_hi && !write_strobe_a_data_port_oe)
    else $error("read with wrong voltage or data driven");
  a_pulse_len: assert property (@(posedge core_clk) disable iff (!reset_n)
    ($fell(write_strobe_a_n) && mode_ready) |-> !write_strobe_a_n [*8])
    else $error("programming pulse too short");
  a_entry_levels: assert property (@(posedge core_clk) disable iff (!reset_n)
    basic_mode_select |-> !write_strobe_a_n && !ext_access_write_strobe_a_voltage_lvl)
    else $error("entry without low strobe and voltage pin");
  a_rsvd_refused: assert property (@(posedge core_clk) disable iff (!reset_n)
    (take && cmd.mode == `OPP_MODE_RSVD) |=> rsp_valid && rsp_error && write_strobe_a_read_strobe_n)
    else $error("reserved mode not refused");
endmodule // opp_programmer
`default_nettype wire

// file: tb/opp_dev_model.sv
// Behavioural OTP device answering the controller in programming mode
`timescale 1ns/100ps
`default_nettype none
module opp_dev_model #(
  parameter logic [7:0] VER = 8'h5A // Arbitrary value
) (
  input wire logic sel_hi,
  input wire logic sel_lo,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic vpp_hi,
  input wire logic [7:0] addr,
  input wire logic [7:0] din,
  output logic [7:0] dout,
  output logic doe
);
  logic [7:0] mem [0:65535];
  logic [7:0] hi_r, wd_r;
  logic [15:0] wa_r;
  logic [1:0] md_r;
  logic [1:0] lock_r = 2'h3;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  always @(negedge ale) hi_r = addr;
  // Answer reads, never reserved; port freed when strobe ends
  always @(rd_n) begin
    if (rd_n !== 1'b0) begin
      doe = 1'b0;
    end else begin
      case ({sel_hi, sel_lo})
        2'h1: dout = VER;
        2'h2: dout = {6'h3F, lock_r};
        2'h3: dout = mem[{hi_r, addr}];
        default: dout = 8'h00;
      endcase
      doe = ({sel_hi, sel_lo} != 2'h0);
    end
  end
  // Capture write byte on strobe fall
  always @(negedge wr_n) begin
    wa_r = {hi_r, addr};
    wd_r = din;
    md_r = {sel_hi, sel_lo};
  end
  // Burn only if strobe ends under programming voltage
  always @(posedge wr_n) begin
    if (vpp_hi && md_r == 2'h3) mem[wa_r] = mem[wa_r] & wd_r;
    if (vpp_hi && md_r == 2'h2) lock_r = lock_r & wd_r[1:0];
  end
endmodule // opp_dev_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the OTP programming-port controller
`timescale 1ns/100ps
`default_nettype none
`include "opp_defines.svh"
module tb;
  import opp_pkg::*;
  localparam logic [7:0] VER = 8'hA5; // Arbitrary value
  localparam int WRITE_STROBE_A = 20; // Short pulse keeps the run brief
  logic core_clk = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0;
  opp_cmd_t cmd = '0;
  logic cmd_ready, rsp_valid, rsp_error, mode_ready, dev_reset_n, cfe_n, bsel, sel_hi, sel_lo;
  logic ale, rd_n, wr_n, vpp_hi, vpp_lvl, oe, dev_oe, p_ale, p_rd, p_wr;
  logic [1:0] p_sel, lock_sh = 2'h3;
  logic [7:0] rsp_data, addr_port, data_o, data_i, dev_dout, last_i = 8'h00;
  logic [7:0] shadow [0:65535];
  int seed = 30, failures = 0, n_checks = 0;
  int bsel_cyc = 0, wr_low = 0;
  always #5 core_clk = ~core_clk;
  opp_programmer #(.WRITE_STROBE_A_CYC(WRITE_STROBE_A)) u_opp_programmer (.core_clk(core_clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid),
    .rsp_error(rsp_error), .rsp_data(rsp_data), .mode_ready(mode_ready), .dev_reset_n(dev_reset_n),
    .code_fetch_enable_n(cfe_n), .basic_mode_select(bsel), .access_sel_hi(sel_hi),
    .access_sel_lo(sel_lo), .addr_latch_strobe(ale), .write_strobe_a_read_strobe_n(rd_n),
    .write_strobe_a_n(wr_n), .ext_access_write_strobe_a_voltage_hi(vpp_hi),
    .ext_access_write_strobe_a_voltage_lvl(vpp_lvl), .muxed_address_port(addr_port),
    .write_strobe_a_data_port_o(data_o), .write_strobe_a_data_port_oe(oe), .write_strobe_a_data_port_i(data_i));
  opp_dev_model #(.VER(VER)) u_opp_dev_model (.sel_hi(sel_hi), .sel_lo(sel_lo), .ale(ale),
    .rd_n(rd_n), .wr_n(wr_n), .vpp_hi(vpp_hi), .addr(addr_port), .din(data_i),
    .dout(dev_dout), .doe(dev_oe));
  // Undriven port shows a changing pattern, never a stale byte
  assign data_i = (oe === 1'b1) ? data_o : ((dev_oe === 1'b1) ? dev_dout : ~last_i);
  always @(posedge core_clk) last_i <= data_i;
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic hung(input logic ok);
    if (!ok) begin
      failures++;
      $display("CHECK FAILED wait exp done got timeout");
      results();
    end
  endtask
  function automatic logic [7:0] exp_rd(input logic [1:0] m, input logic [15:0] a);
    if (m == 2'h1) return VER;
    if (m == 2'h2) return {6'h3F, lock_sh};
    return shadow[a];
  endfunction
  // One command: offer, wait until taken, wait for answer
  task automatic do_cmd(input logic w, input logic [1:0] m, input logic [15:0] a, input logic [7:0] d);
    int i;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd <= '{write: w, mode: m, addr: a, data: d};
    i = 0;
    do begin @(negedge core_clk); i++; end while (cmd_ready !== 1'b1 && i < 300);
    hung(cmd_ready === 1'b1);
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    i = 0;
    do begin @(negedge core_clk); i++; end while (rsp_valid !== 1'b1 && i < 400);
    hung(rsp_valid === 1'b1);
    check("rsp_error", 16'(m == 2'h0), 16'(rsp_error));
    if (!w && m != 2'h0) check("rsp_data", 16'(exp_rd(m, a)), 16'(rsp_data));
    if (w && m == 2'h3) shadow[a] = shadow[a] & d;
    if (w && m == 2'h2) lock_sh = lock_sh & d[1:0];
  endtask
  // Pin watch, sampled away from the launching edge
  always @(negedge core_clk) begin
    if (reset_n) begin
      check("dev_reset_n", 16'h0, 16'(dev_reset_n));
      check("fetch_en_n", 16'h0, 16'(cfe_n));
      if ({sel_hi, sel_lo} != p_sel) check("ale_at_sel", 16'h0, 16'(ale | p_ale));
      if (p_ale && !ale) check("addr_hi", 16'(cmd.addr[15:8]), 16'(addr_port));
      if (p_rd && !rd_n) check("addr_lo_rd", 16'(cmd.addr[7:0]), 16'(addr_port));
      if (p_wr && !wr_n && mode_ready) check("addr_lo_wr", 16'(cmd.addr[7:0]), 16'(addr_port));
      if (!wr_n && mode_ready) check("vpp_write_strobe_a", 16'h3, {14'h0, vpp_hi, oe});
      if (!p_wr && wr_n && vpp_hi) check("pulse_len", 16'(WRITE_STROBE_A), 16'(wr_low));
      if (!rd_n) check("vpp_read", 16'h1, {14'h0, vpp_hi, vpp_lvl});
      check("bus_clash", 16'h0, 16'(oe & dev_oe));
      if (!mode_ready) check("entry_pins", 16'h0, {12'h0, cmd_ready, wr_n, vpp_hi, vpp_lvl});
      if (mode_ready) check("mode_sel_idle", 16'h0, 16'(bsel));
      if (mode_ready && {sel_hi, sel_lo} == 2'h0) check("rsvd_quiet", 16'h6, {13'h0, rd_n, wr_n, ale});
      // Select high time and write strobe low time, counted per edge
      if (bsel) bsel_cyc++;
      wr_low = wr_n ? 0 : wr_low + 1;
    end
    p_ale = ale;
    p_rd = rd_n;
    p_wr = wr_n;
    p_sel = {sel_hi, sel_lo};
  end
  // Main sequence: corners first, then random traffic
  initial begin
    logic [31:0] r;
    foreach (shadow[i]) shadow[i] = 8'hFF;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    do_cmd(1'b1, 2'h3, 16'hFFFF, 8'h3C);
    check("bsel_len", 16'(`OPP_STEP_CYC + 1), 16'(bsel_cyc));
    do_cmd(1'b0, 2'h3, 16'hFFFF, 8'h00);
    do_cmd(1'b1, 2'h3, 16'h0000, 8'hA5);
    do_cmd(1'b1, 2'h3, 16'h0000, 8'h0F);
    do_cmd(1'b0, 2'h3, 16'h0000, 8'h00);
    check("mode_ready", 16'h1, 16'(mode_ready));
    for (int k = 0; k < 8; k++) do_cmd(k[2], k[1:0], 16'h8001, 8'hFD);
    do_cmd(1'b0, 2'h2, 16'h0000, 8'h00);
    for (int n = 0; n < 40; n++) begin
      r = $random(seed);
      do_cmd(r[8], r[10:9], r[31:16] & 16'hC003, r[7:0]);
    end
    results();
  end
endmodule // tb
`default_nettype wire
